/* File: rtl/wkmgr_top.sv */
// Wake manager: wake source filtering, mode gating, cause registers
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module wkmgr_top (
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_in,
  input  wire logic                          reset_class2_in,
  input  wire logic                          reset_class3_in,
  input  wire logic [11:0]                   addr_in,
  input  wire logic [31:0]                   wdata_in,
  input  wire logic                          wr_in,
  input  wire logic                          rd_in,
  output logic      [31:0]                   rdata_out,
  input  wire logic [wkmgr_pkg::PIN_N-1:0]   p0_pin_in,
  input  wire logic [wkmgr_pkg::PIN_N-1:0]   p1_pin_in,
  input  wire logic                          lin_wake_in,
  input  wire logic                          hv_sense_in,
  input  wire logic                          hv_sense_rise_sel_in,
  input  wire logic                          reset_pin_n_in,
  input  wire logic                          supply_ov_in,
  input  wire logic                          supply_short_in,
  input  wire logic                          supply_on_in,
  input  wire logic                          cyclic_wake_in,
  output logic                               wake_req_out,
  output logic                               wake_mode_stop_out
);

  // ************************************************************
  // Input synchronisers (two flops before any logic)
  // ************************************************************
  localparam int SN = 2 * wkmgr_pkg::PIN_N + 8;
  logic [SN-1:0] meta_r;
  logic [SN-1:0] sync_r;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {p1_pin_in, p0_pin_in, lin_wake_in, hv_sense_in, hv_sense_rise_sel_in,
                 ~reset_pin_n_in, supply_ov_in, supply_short_in, supply_on_in,
                 cyclic_wake_in};
      sync_r <= meta_r;
    end
  end
  wire [wkmgr_pkg::PIN_N-1:0] p1_s      = sync_r[SN-1 -: wkmgr_pkg::PIN_N];
  wire [wkmgr_pkg::PIN_N-1:0] p0_s      = sync_r[8 +: wkmgr_pkg::PIN_N];
  wire                        lin_s     = sync_r[7];
  wire                        sense_s   = sync_r[6];
  wire                        sense_rs  = sync_r[5];
  wire                        rstpin_s  = sync_r[4];
  wire                        ov_s      = sync_r[3];
  wire                        short_s   = sync_r[2];
  wire                        supon_s   = sync_r[1];
  wire                        cyc_s     = sync_r[0];

  // ************************************************************
  // Configuration registers
  // ************************************************************
  wkmgr_pkg::wkmgr_portcfg_s p0_cfg_r;
  wkmgr_pkg::wkmgr_portcfg_s p1_cfg_r;
  logic [3:0]                filt_r;
  logic                      lin_en_r;
  wkmgr_pkg::wkmgr_mode_e    mode_r;

  wire wr_p0r  = wr_in && (addr_in == wkmgr_pkg::OFS_P0_RISE);
  wire wr_p0f  = wr_in && (addr_in == wkmgr_pkg::OFS_P0_FALL);
  wire wr_p0c  = wr_in && (addr_in == wkmgr_pkg::OFS_P0_CYC);
  wire wr_p1r  = wr_in && (addr_in == wkmgr_pkg::OFS_P1_RISE);
  wire wr_p1f  = wr_in && (addr_in == wkmgr_pkg::OFS_P1_FALL);
  wire wr_p1c  = wr_in && (addr_in == wkmgr_pkg::OFS_P1_CYC);
  wire wr_flt  = wr_in && (addr_in == wkmgr_pkg::OFS_FILTER);
  wire wr_lin  = wr_in && (addr_in == wkmgr_pkg::OFS_LIN_EN);
  wire wr_mode = wr_in && (addr_in == wkmgr_pkg::OFS_MODE_CTRL);
  wire [4:0] wpin = wdata_in[wkmgr_pkg::PIN_N-1:0];

  // Third reset class clears port configuration only
  always_ff @(posedge ref_clk_in or posedge reset_class3_in) begin
    if (reset_class3_in) begin
      p0_cfg_r <= '0;
      p1_cfg_r <= '0;
    end else begin
      if (wr_p0r) p0_cfg_r.rise <= wpin;
      if (wr_p0f) p0_cfg_r.fall <= wpin;
      if (wr_p0c) p0_cfg_r.cyc  <= wpin;
      if (wr_p1r) p1_cfg_r.rise <= wpin;
      if (wr_p1f) p1_cfg_r.fall <= wpin;
      if (wr_p1c) p1_cfg_r.cyc  <= wpin;
    end
  end

  // Second reset class clears filter timing and LIN enable
  always_ff @(posedge ref_clk_in or posedge reset_class2_in) begin
    if (reset_class2_in) begin
      filt_r   <= wkmgr_pkg::RST_ZERO[3:0];
      lin_en_r <= 1'b0;
    end else begin
      if (wr_flt) filt_r <= wdata_in[3:0];
      if (wr_lin) lin_en_r <= wdata_in[wkmgr_pkg::LIN_EN_BIT];
    end
  end

  // ************************************************************
  // Filter time selection
  // ************************************************************
  function automatic logic [wkmgr_pkg::CNT_W-1:0] cyc_of(input int n);
    cyc_of = n[wkmgr_pkg::CNT_W-1:0];
  endfunction : cyc_of

  wire [1:0] port_ft = filt_r[wkmgr_pkg::PORT_FT_HI:wkmgr_pkg::PORT_FT_LO];
  wire [wkmgr_pkg::CNT_W-1:0] port_lim =
      (port_ft == 2'b00) ? cyc_of(wkmgr_pkg::FT_10US_CYC) :
      (port_ft == 2'b01) ? cyc_of(wkmgr_pkg::FT_20US_CYC) :
      (port_ft == 2'b10) ? cyc_of(wkmgr_pkg::FT_40US_CYC) :
                           cyc_of(wkmgr_pkg::FT_5US_CYC);
  wire [wkmgr_pkg::CNT_W-1:0] sense_lim = filt_r[wkmgr_pkg::SENSE_FT_BIT] ?
      cyc_of(wkmgr_pkg::FT_40US_CYC) : cyc_of(wkmgr_pkg::FT_20US_CYC);
  wire [wkmgr_pkg::CNT_W-1:0] lin_lim = filt_r[wkmgr_pkg::LIN_FT_BIT] ?
      cyc_of(wkmgr_pkg::FT_50US_CYC) : cyc_of(wkmgr_pkg::FT_30US_CYC);

  // ************************************************************
  // Filters: ten port pins, sense input, LIN
  // ************************************************************
  localparam int FN = 2 * wkmgr_pkg::PIN_N + 2;
  wire [FN-1:0] f_raw = {lin_s, sense_s, p1_s, p0_s};
  logic [FN-1:0] f_lvl;
  logic [FN-1:0] f_rise;
  logic [FN-1:0] f_fall;
  genvar gi;
  generate
    for (gi = 0; gi < FN; gi++) begin : g_flt
      wkmgr_filter u_flt (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .raw_in     (f_raw[gi]),
        .limit_in   ((gi == FN-1) ? lin_lim : (gi == FN-2) ? sense_lim : port_lim),
        .level_out  (f_lvl[gi]),
        .rise_out   (f_rise[gi]),
        .fall_out   (f_fall[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Wake qualification
  // ************************************************************
  // Port 2 has no input here at all, so it can never wake the block
  wire in_stop  = (mode_r == wkmgr_pkg::WKMGR_STOP);
  wire in_sleep = (mode_r == wkmgr_pkg::WKMGR_SLEEP);
  wire in_low   = in_stop || in_sleep;

  function automatic logic [4:0] port_hit(input wkmgr_pkg::wkmgr_portcfg_s c,
                                          input logic [4:0] r, input logic [4:0] f,
                                          input logic son);
    port_hit = ((r & c.rise) | (f & c.fall))
             & (~c.cyc | {5{son}});
  endfunction : port_hit

  wire [4:0] p0_hit = in_stop ? port_hit(p0_cfg_r, f_rise[4:0], f_fall[4:0], supon_s)
                              : 5'b0_0000;
  wire [4:0] p1_hit = in_stop ? port_hit(p1_cfg_r, f_rise[9:5], f_fall[9:5], supon_s)
                              : 5'b0_0000;
  wire sense_hit = in_low && (sense_rs ? f_rise[10] : f_fall[10]);
  wire lin_hit   = in_low && lin_en_r && f_rise[11];
  wire rst_hit   = in_stop && rstpin_s;
  wire fail_hit  = in_stop && (ov_s || short_s);
  wire cyc_hit   = in_low && cyc_s;
  wire any_hit   = (|p0_hit) || (|p1_hit) || sense_hit || lin_hit || rst_hit
                 || fail_hit || cyc_hit;

  // ************************************************************
  // Cause flags (clear on read, set wins)
  // ************************************************************
  logic [4:0] p0_cause_r;
  logic [4:0] p1_cause_r;
  logic       sense_cause_r;
  logic       lin_cause_r;
  logic       cyc_cause_r;
  logic [1:0] fail_cause_r;
  wire rd_main  = rd_in && (addr_in == wkmgr_pkg::OFS_MAIN_CAUSE);
  wire rd_sense = rd_in && (addr_in == wkmgr_pkg::OFS_SENSE_CAUSE);
  wire rd_p0    = rd_in && (addr_in == wkmgr_pkg::OFS_P0_CAUSE);
  wire rd_p1    = rd_in && (addr_in == wkmgr_pkg::OFS_P1_CAUSE);
  wire rd_fail  = rd_in && (addr_in == wkmgr_pkg::OFS_FAIL_CAUSE);

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      p0_cause_r    <= '0;
      p1_cause_r    <= '0;
      sense_cause_r <= 1'b0;
      lin_cause_r   <= 1'b0;
      cyc_cause_r   <= 1'b0;
      fail_cause_r  <= '0;
    end else begin
      p0_cause_r    <= p0_hit | (rd_p0 ? 5'b0_0000 : p0_cause_r);
      p1_cause_r    <= p1_hit | (rd_p1 ? 5'b0_0000 : p1_cause_r);
      sense_cause_r <= sense_hit || (!rd_sense && sense_cause_r);
      lin_cause_r   <= lin_hit || (!rd_main && lin_cause_r);
      cyc_cause_r   <= cyc_hit || (!rd_main && cyc_cause_r);
      fail_cause_r  <= {fail_hit && short_s, fail_hit && ov_s}
                     | (rd_fail ? 2'b00 : fail_cause_r);
    end
  end

  // ************************************************************
  // Mode control and startup request
  // ************************************************************
  // Request follows the flags by one cycle, so causes are visible first
  logic any_hit_r;
  logic wake_req_r;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode_r     <= wkmgr_pkg::WKMGR_ACTIVE;
      any_hit_r  <= 1'b0;
      wake_req_r <= 1'b0;
    end else begin
      any_hit_r  <= any_hit;
      wake_req_r <= any_hit_r;
      case (mode_r)
        wkmgr_pkg::WKMGR_ACTIVE: begin
          if (wr_mode && wdata_in[1:0] == 2'b01) mode_r <= wkmgr_pkg::WKMGR_STOP;
          else if (wr_mode && wdata_in[1:0] == 2'b10) mode_r <= wkmgr_pkg::WKMGR_SLEEP;
        end
        default: begin
          if (any_hit) mode_r <= wkmgr_pkg::WKMGR_ACTIVE;
        end
      endcase
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  wire [7:0] main_val = {2'b00, |fail_cause_r, cyc_cause_r, |p1_cause_r, |p0_cause_r,
                         sense_cause_r, lin_cause_r};
  wire [31:0] rd_val =
      (addr_in == wkmgr_pkg::OFS_MAIN_CAUSE)  ? {24'h00_0000, main_val} :
      (addr_in == wkmgr_pkg::OFS_LIN_EN)      ? {24'h00_0000, lin_en_r, 7'h00} :
      (addr_in == wkmgr_pkg::OFS_SENSE_CAUSE) ? {31'h0000_0000, sense_cause_r} :
      (addr_in == wkmgr_pkg::OFS_P0_CAUSE)    ? {27'h000_0000, p0_cause_r} :
      (addr_in == wkmgr_pkg::OFS_P1_CAUSE)    ? {27'h000_0000, p1_cause_r} :
      (addr_in == wkmgr_pkg::OFS_FILTER)      ? {28'h000_0000, filt_r} :
      (addr_in == wkmgr_pkg::OFS_P0_RISE)     ? {27'h000_0000, p0_cfg_r.rise} :
      (addr_in == wkmgr_pkg::OFS_P0_FALL)     ? {27'h000_0000, p0_cfg_r.fall} :
      (addr_in == wkmgr_pkg::OFS_P0_CYC)      ? {27'h000_0000, p0_cfg_r.cyc} :
      (addr_in == wkmgr_pkg::OFS_P1_RISE)     ? {27'h000_0000, p1_cfg_r.rise} :
      (addr_in == wkmgr_pkg::OFS_P1_FALL)     ? {27'h000_0000, p1_cfg_r.fall} :
      (addr_in == wkmgr_pkg::OFS_P1_CYC)      ? {27'h000_0000, p1_cfg_r.cyc} :
      (addr_in == wkmgr_pkg::OFS_MODE_CTRL)   ? {30'h0000_0000, mode_r} :
      (addr_in == wkmgr_pkg::OFS_FAIL_CAUSE)  ? {29'h0000_0000, fail_cause_r[1], 1'b0,
                                                 fail_cause_r[0]} :
      wkmgr_pkg::RD_UNMAPPED;

  logic [31:0] rdata_r;
  logic        stop_r;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_r <= '0;
      stop_r  <= 1'b0;
    end else begin
      rdata_r <= rd_in ? rd_val : 32'h0000_0000;
      stop_r  <= in_stop;
    end
  end
  assign rdata_out          = rdata_r;
  assign wake_req_out       = wake_req_r;
  assign wake_mode_stop_out = stop_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_sleep_no_port;
    @(posedge ref_clk_in) disable iff (reset_in) in_sleep |-> (p0_hit == 5'b0_0000);
  endproperty
  a_sleep_no_port: assert property (p_sleep_no_port) else $error("port wake in sleep");

  property p_rst_stop_only;
    @(posedge ref_clk_in) disable iff (reset_in) rst_hit |-> !in_sleep && in_stop;
  endproperty
  a_rst_stop_only: assert property (p_rst_stop_only) else $error("reset pin wake bad mode");

  property p_fail_wakes;
    @(posedge ref_clk_in) disable iff (reset_in)
      (in_stop && ov_s) |=> (mode_r == wkmgr_pkg::WKMGR_ACTIVE) ##1 wake_req_r;
  endproperty
  a_fail_wakes: assert property (p_fail_wakes) else $error("supply fault no wake");

  property p_req_after_flag;
    @(posedge ref_clk_in) disable iff (reset_in) (lin_hit || sense_hit) |-> ##2 wake_req_r;
  endproperty
  a_req_after_flag: assert property (p_req_after_flag) else $error("no startup request");

  property p_rc_clear;
    @(posedge ref_clk_in) disable iff (reset_in)
      (rd_p0 && p0_hit == 5'b0_0000) |=> (p0_cause_r == 5'b0_0000);
  endproperty
  a_rc_clear: assert property (p_rc_clear) else $error("cause not cleared on read");

  property p_set_wins;
    @(posedge ref_clk_in) disable iff (reset_in) (rd_sense && sense_hit) |=> sense_cause_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on read");

  property p_summary_or;
    @(posedge ref_clk_in) disable iff (reset_in)
      rd_main |=> rdata_r[wkmgr_pkg::MAIN_P1_BIT] == $past(|p1_cause_r);
  endproperty
  a_summary_or: assert property (p_summary_or) else $error("summary flag wrong");

  property p_cyc_gate;
    @(posedge ref_clk_in) disable iff (reset_in)
      (!supon_s && p0_cfg_r.cyc[0]) |-> !p0_hit[0];
  endproperty
  a_cyc_gate: assert property (p_cyc_gate) else $error("cyclic pin woke without supply");

  property p_lin_off;
    @(posedge ref_clk_in) disable iff (reset_in) !lin_en_r |-> !lin_hit;
  endproperty
  a_lin_off: assert property (p_lin_off) else $error("disabled LIN woke");

  property p_reserved_zero;
    @(posedge ref_clk_in) disable iff (reset_in)
      $past(rd_in && addr_in == wkmgr_pkg::OFS_P0_RISE) |-> rdata_r[7:5] == 3'b000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  c_port_wake:  cover property (@(posedge ref_clk_in) |p0_hit);
  c_sense_wake: cover property (@(posedge ref_clk_in) sense_hit && in_sleep);
  c_lin_wake:   cover property (@(posedge ref_clk_in) lin_hit);
  c_fail_wake:  cover property (@(posedge ref_clk_in) fail_hit);

endmodule : wkmgr_top

/* File: rtl/wkmgr_pkg.sv */
// Package: register map, field layout and filter timing for the wake manager
package wkmgr_pkg;

  // ************************************************************
  // Register offsets (byte addresses, word aligned)
  // ************************************************************
  localparam logic [11:0] OFS_MAIN_CAUSE   = 12'h000;
  localparam logic [11:0] OFS_LIN_EN       = 12'h050;
  localparam logic [11:0] OFS_SENSE_CAUSE  = 12'h084;
  localparam logic [11:0] OFS_P0_CAUSE     = 12'h088;
  localparam logic [11:0] OFS_P1_CAUSE     = 12'h08c;
  localparam logic [11:0] OFS_FILTER       = 12'h0ac;
  localparam logic [11:0] OFS_P0_RISE      = 12'h0d8;
  localparam logic [11:0] OFS_P0_FALL      = 12'h0dc;
  localparam logic [11:0] OFS_P0_CYC       = 12'h0e0;
  localparam logic [11:0] OFS_P1_RISE      = 12'h0e4;
  localparam logic [11:0] OFS_P1_FALL      = 12'h0e8;
  localparam logic [11:0] OFS_P1_CYC       = 12'h0ec;
  localparam logic [11:0] OFS_MODE_CTRL    = 12'h0f0;
  localparam logic [11:0] OFS_FAIL_CAUSE   = 12'h0f4;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int          PIN_N            = 5;
  localparam int          LIN_EN_BIT       = 7;
  localparam int          PORT_FT_HI       = 3;
  localparam int          PORT_FT_LO       = 2;
  localparam int          SENSE_FT_BIT     = 1;
  localparam int          LIN_FT_BIT       = 0;
  localparam int          MAIN_LIN_BIT     = 0;
  localparam int          MAIN_SENSE_BIT   = 1;
  localparam int          MAIN_P0_BIT      = 2;
  localparam int          MAIN_P1_BIT      = 3;
  localparam int          MAIN_CYC_BIT     = 4;
  localparam int          MAIN_FAIL_BIT    = 5;
  localparam int          FAIL_OV_BIT      = 0;
  localparam int          FAIL_SHORT_BIT   = 2;
  localparam logic [7:0]  RST_ZERO         = 8'h00;
  localparam logic [31:0] RD_UNMAPPED      = 32'h0000_0000;

  // ************************************************************
  // Filter times in ns and derived cycle counts at 100 MHz
  // ************************************************************
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          FT_5US_NS        = 5000;
  localparam int          FT_10US_NS       = 10000;
  localparam int          FT_20US_NS       = 20000;
  localparam int          FT_30US_NS       = 30000;
  localparam int          FT_40US_NS       = 40000;
  localparam int          FT_50US_NS       = 50000;
  localparam int          FT_5US_CYC       = (FT_5US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FT_10US_CYC      = (FT_10US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FT_20US_CYC      = (FT_20US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FT_30US_CYC      = (FT_30US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FT_40US_CYC      = (FT_40US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FT_50US_CYC      = (FT_50US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W            = 13;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    WKMGR_ACTIVE,
    WKMGR_STOP,
    WKMGR_SLEEP
  } wkmgr_mode_e;

  typedef struct packed {
    logic [PIN_N-1:0] rise;
    logic [PIN_N-1:0] fall;
    logic [PIN_N-1:0] cyc;
  } wkmgr_portcfg_s;

endpackage : wkmgr_pkg

/* File: rtl/wkmgr_filter.sv */
// Glitch filter: a new level is taken only after it stays stable for the limit
`timescale 1ns/10ps
module wkmgr_filter (
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_in,
  input  wire logic                          raw_in,
  input  wire logic [wkmgr_pkg::CNT_W-1:0]   limit_in,
  output logic                               level_out,
  output logic                               rise_out,
  output logic                               fall_out
);

  logic [wkmgr_pkg::CNT_W-1:0] cnt_r;
  logic                        level_r;
  logic                        rise_r;
  logic                        fall_r;
  wire                         differs = (raw_in != level_r);
  wire                         done    = differs && (cnt_r >= limit_in - 1'b1);

  // ************************************************************
  // Stability counter
  // ************************************************************
  // Counter restarts on any bounce, so short pulses never reach the limit
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_r   <= '0;
      level_r <= 1'b0;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
    end else begin
      cnt_r   <= (differs && !done) ? cnt_r + 1'b1 : '0;
      level_r <= done ? raw_in : level_r;
      rise_r  <= done && raw_in;
      fall_r  <= done && !raw_in;
    end
  end

  assign level_out = level_r;
  assign rise_out  = rise_r;
  assign fall_out  = fall_r;

endmodule : wkmgr_filter

/* File: sim/wkmgr_far.sv */
// Far-side model: port pins, LIN transceiver, sense input, reset pin, supply faults
`timescale 1ns/10ps
module wkmgr_far (
  input  wire logic                   ref_clk_in,
  output logic [wkmgr_pkg::PIN_N-1:0] p0_out,
  output logic [wkmgr_pkg::PIN_N-1:0] p1_out,
  output logic                        lin_out,
  output logic                        hv_out,
  output logic                        rst_pin_n_out,
  output logic                        ov_out,
  output logic                        short_out
);
  initial begin
    {short_out, ov_out, rst_pin_n_out, hv_out, lin_out, p1_out, p0_out} = 15'h1000;
  end
  // Levels move just after an edge, as a slow external pin would
  task automatic drive(input logic [14:0] lv);
    @(posedge ref_clk_in);
    {short_out, ov_out, rst_pin_n_out, hv_out, lin_out, p1_out, p0_out} <= lv;
  endtask : drive
endmodule : wkmgr_far

/* File: sim/wkmgr_top_tb.sv */
// Testbench: register map, class resets and wake paths of the wake manager
`timescale 1ns/10ps
module wkmgr_top_tb;
  // ****
  // Harness
  // ****
  logic        clk, rst, c2, c3, wr, rd, wake, stp, lin, hv, rstn, ov, sht;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [4:0]  p0, p1;
  logic        sel, son, cw;
  int          n_errors, n_compared, cyc;
  logic [11:0] ofs [8] = '{12'h050, 12'h0ac, 12'h0d8, 12'h0dc, 12'h0e0, 12'h0e4, 12'h0e8, 12'h0ec};
  wkmgr_far far (.ref_clk_in(clk), .p0_out(p0), .p1_out(p1), .lin_out(lin), .hv_out(hv),
    .rst_pin_n_out(rstn), .ov_out(ov), .short_out(sht));
  wkmgr_top uut (.ref_clk_in(clk), .reset_in(rst), .reset_class2_in(c2), .reset_class3_in(c3),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .p0_pin_in(p0), .p1_pin_in(p1), .lin_wake_in(lin), .hv_sense_in(hv),
    .hv_sense_rise_sel_in(sel), .reset_pin_n_in(rstn), .supply_ov_in(ov),
    .supply_short_in(sht), .supply_on_in(son), .cyclic_wake_in(cw),
    .wake_req_out(wake), .wake_mode_stop_out(stp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check($sformatf("reg %h", a), rdata, e);
  endtask : rd_chk
  task automatic pulse(input logic k);
    @(posedge clk);
    if (k) c3 <= 1'b1;
    else c2 <= 1'b1;
    @(posedge clk);
    c2 <= 1'b0;
    c3 <= 1'b0;
  endtask : pulse
  // Long settle lets filtered edges left by a source drain while active
  task automatic idle_wait();
    far.drive(15'h1000);
    repeat (6000) @(posedge clk);
  endtask : idle_wait
  task automatic go(input logic [1:0] md, input logic [14:0] lv);
    wr_reg(12'h0f0, {30'h0, md});
    far.drive(lv);
    #1 check("stop", {31'h0, stp}, {31'h0, md == 2'd1});
  endtask : go
  task automatic wake_in(input int lo, input int hi, input logic ew);
    int n;
    n = 0;
    while (wake !== 1'b1 && n < hi) begin
      @(posedge clk);
      #1 n++;
    end
    check("wake", {31'h0, wake === 1'b1 && n >= lo}, {31'h0, ew});
  endtask : wake_in
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      rd_chk(ofs[i], 32'h0000_0000);
      wr_reg(ofs[i], 32'hffff_ffff);
      rd_chk(ofs[i], i == 0 ? 32'h0000_0080 : i == 1 ? 32'h0000_000f : 32'h0000_001f);
    end
    rd_chk(12'h004, 32'h0000_0000);
    pulse(1'b0);
    for (int i = 0; i < 8; i++) rd_chk(ofs[i], i < 2 ? 32'h0000_0000 : 32'h0000_001f);
    pulse(1'b1);
    for (int i = 0; i < 8; i++) rd_chk(ofs[i], 32'h0000_0000);
  endtask : t_regs
  task automatic t_port();
    wr_reg(12'h0ac, 32'h0000_000c);
    wr_reg(12'h0d8, 32'h0000_0001);
    go(2'd1, 15'h1001);
    wake_in(wkmgr_pkg::FT_5US_CYC, 900, 1'b1);
    rd_chk(12'h000, 32'h0000_0004);
    rd_chk(12'h088, 32'h0000_0001);
    rd_chk(12'h088, 32'h0000_0000);
    idle_wait();
  endtask : t_port
  task automatic t_sleep();
    wr_reg(12'h0e4, 32'h0000_0010);
    go(2'd2, 15'h1200);
    wake_in(0, 1500, 1'b0);
    far.drive(15'h1a00);
    wake_in(wkmgr_pkg::FT_20US_CYC, 2600, 1'b1);
    rd_chk(12'h000, 32'h0000_0002);
    rd_chk(12'h084, 32'h0000_0001);
    rd_chk(12'h08c, 32'h0000_0000);
    idle_wait();
  endtask : t_sleep
  task automatic t_lin();
    wr_reg(12'h050, 32'h0000_0080);
    go(2'd2, 15'h0000);
    wake_in(0, 1500, 1'b0);
    far.drive(15'h0400);
    wake_in(wkmgr_pkg::FT_30US_CYC, 3600, 1'b1);
    rd_chk(12'h000, 32'h0000_0001);
    rd_chk(12'h000, 32'h0000_0000);
    idle_wait();
  endtask : t_lin
  task automatic t_exits();
    go(2'd1, 15'h0000);
    wake_in(0, 6000, 1'b1);
    idle_wait();
    go(2'd1, 15'h3000);
    wake_in(0, 6000, 1'b1);
    rd_chk(12'h000, 32'h0000_0020);
    rd_chk(12'h0f4, 32'h0000_0001);
    idle_wait();
    go(2'd1, 15'h5000);
    wake_in(0, 20, 1'b1);
    rd_chk(12'h0f4, 32'h0000_0004);
    idle_wait();
  endtask : t_exits
  // Cyclic pin gating, falling edges, sense fall select, cyclic wake
  task automatic t_misc();
    wr_reg(12'h0e8, 32'h0000_0001);
    wr_reg(12'h0ec, 32'h0000_0001);
    @(posedge clk);
    son <= 1'b0;
    sel <= 1'b0;
    far.drive(15'h1020);
    repeat (600) @(posedge clk);
    go(2'd1, 15'h1000);
    wake_in(0, 1500, 1'b0);
    @(posedge clk);
    son <= 1'b1;
    far.drive(15'h1020);
    repeat (600) @(posedge clk);
    far.drive(15'h1000);
    wake_in(wkmgr_pkg::FT_5US_CYC, 900, 1'b1);
    rd_chk(12'h000, 32'h0000_0008);
    rd_chk(12'h08c, 32'h0000_0001);
    far.drive(15'h1800);
    repeat (2100) @(posedge clk);
    go(2'd1, 15'h1000);
    wake_in(wkmgr_pkg::FT_20US_CYC, 2600, 1'b1);
    rd_chk(12'h084, 32'h0000_0001);
    go(2'd2, 15'h1000);
    @(posedge clk);
    cw <= 1'b1;
    wake_in(0, 20, 1'b1);
    @(posedge clk);
    cw <= 1'b0;
    rd_chk(12'h000, 32'h0000_0010);
    rd_chk(12'h000, 32'h0000_0000);
  endtask : t_misc
  initial begin
    {rst, c2, c3, wr, rd, addr, wdata} = '1;
    {sel, son, cw} = 3'b110;
    {wr, rd, addr, wdata, cyc, n_errors, n_compared} = '0;
    repeat (20) @(posedge clk);
    {rst, c2, c3} <= 3'h0;
    t_regs();
    idle_wait();
    t_port();
    t_sleep();
    t_lin();
    t_exits();
    t_misc();
    stop_test();
  end
endmodule : wkmgr_top_tb
